/* rtl/cfg_link_if.sv */
`timescale 1ns/10ps
interface cfg_link_if;
    logic serial_clock;
    logic serial_data;
    logic enable_n;
    logic regulator_power_up;
    logic transceiver_power_up;
    logic rx_on;
    logic tx_on;
    logic open_loop_disable;
    modport device (
        input serial_clock, serial_data, enable_n, regulator_power_up,
        input transceiver_power_up, rx_on, tx_on, open_loop_disable
    );
    modport host (
        output serial_clock, serial_data, enable_n, regulator_power_up,
        output transceiver_power_up, rx_on, tx_on, open_loop_disable
    );
endinterface

/* rtl/cfg_port_device.sv */
`timescale 1ns/10ps
module cfg_port_device
    import cfg_port_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    cfg_link_if.device link,
    output logic ref_select_q,
    output logic [6:0] main_divisor_q,
    output logic [4:0] swallow_divisor_q,
    output logic [11:0] freq_code_q,
    output logic [7:0] deviation_pct_q,
    output logic clock_recovery_q,
    output logic tx_word_q,
    output logic word_valid_q,
    output logic regulators_on_q,
    output logic shared_blocks_on_q,
    output logic rx_chain_on_q,
    output logic tx_chain_on_q,
    output logic open_loop_allowed_q,
    output logic config_strobe_q
);
    import cfg_port_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [7:0] pin_meta_q, pin_sync_q;
    logic sclk_prev_q, en_prev_q;
    wire logic [7:0] pins = {link.serial_clock, link.serial_data,
        link.enable_n, link.regulator_power_up, link.transceiver_power_up,
        link.rx_on, link.tx_on, link.open_loop_disable};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_q <= 8'h20;
            pin_sync_q <= 8'h20;
            sclk_prev_q <= 1'b0;
            en_prev_q <= 1'b1;
        end
        else
        begin
            pin_meta_q <= pins;
            pin_sync_q <= pin_meta_q;
            sclk_prev_q <= pin_sync_q[7];
            en_prev_q <= pin_sync_q[5];
        end
    end

    wire logic sclk_s = pin_sync_q[7];
    wire logic sdata_s = pin_sync_q[6];
    wire logic en_n_s = pin_sync_q[5];
    wire logic shift_now = sclk_s && !sclk_prev_q && !en_n_s;
    wire logic latch_now = en_n_s && !en_prev_q;

    // ----------------------------------------
    // shift register
    // ----------------------------------------
    // no counter: old bits fall off the top
    logic [WORD_BITS-1:0] shift_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shift_q <= '0;
        else if (shift_now)
            shift_q <= {shift_q[WORD_BITS-2:0], sdata_s};
    end

    // ----------------------------------------
    // word decode
    // ----------------------------------------
    function automatic logic [6:0] main_of(input logic [1:0] code);
        main_of = MAIN_BASE + {5'h00, code};
    endfunction

    wire logic is_recovery =
        shift_q[WORD_BITS-1:PREFIX_LSB] == RECOVERY_PREFIX;
    wire logic is_tx = shift_q[MODE_BIT] && shift_q[RX_TX_BIT];
    wire logic rec_ok = is_recovery && !shift_q[TOP_BIT]
        && !shift_q[MODE_BIT] && !shift_q[RX_TX_BIT];
    wire logic plain_ok = !shift_q[TOP_BIT] && shift_q[MODE_BIT]
        && !shift_q[RX_TX_BIT];
    wire logic [1:0] main_code = shift_q[MAIN_LSB+1:MAIN_LSB];
    wire logic [4:0] swallow = shift_q[SWALLOW_LSB+4:SWALLOW_LSB];
    wire logic [6:0] main_div = main_of(main_code);
    wire logic [11:0] sum_code = {main_div, 5'h00} + {7'h00, swallow};
    wire logic [11:0] freq_code = is_tx ? sum_code
        : sum_code - 12'h001;
    wire logic [2:0] trim = shift_q[TRIM_LSB+2:TRIM_LSB];
    wire logic [7:0] trim_pct = ({4'h0, TRIM_BASE_PCT} + {5'h00, trim})
        * 8'h0A;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_select_q <= 1'b0;
            main_divisor_q <= MAIN_BASE;
            swallow_divisor_q <= 5'h00;
            freq_code_q <= 12'h000;
            deviation_pct_q <= 8'h64;
            clock_recovery_q <= 1'b0;
            tx_word_q <= 1'b0;
            word_valid_q <= 1'b0;
            config_strobe_q <= 1'b0;
        end
        else
        begin
            config_strobe_q <= latch_now;
            if (latch_now)
            begin
                ref_select_q <= shift_q[REF_SEL_BIT];
                main_divisor_q <= main_div;
                swallow_divisor_q <= swallow;
                freq_code_q <= freq_code;
                // only the enable; recovered clock edges are analog
                clock_recovery_q <= rec_ok;
                tx_word_q <= is_tx && !is_recovery;
                word_valid_q <= rec_ok || (plain_ok && !is_recovery);
                // receive words leave the trim untouched
                if (is_tx && !is_recovery)
                    deviation_pct_q <= trim_pct;
            end
        end
    end

    // ----------------------------------------
    // control lines
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            regulators_on_q <= 1'b0;
            shared_blocks_on_q <= 1'b0;
            rx_chain_on_q <= 1'b0;
            tx_chain_on_q <= 1'b0;
            open_loop_allowed_q <= 1'b0;
        end
        else
        begin
            regulators_on_q <= pin_sync_q[4];
            shared_blocks_on_q <= pin_sync_q[3];
            rx_chain_on_q <= pin_sync_q[2];
            tx_chain_on_q <= pin_sync_q[1];
            open_loop_allowed_q <= !pin_sync_q[0];
        end
    end
endmodule

/* rtl/cfg_port_host.sv */
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// - shift data on clock rise while enable low
// - enable rising latches word into configuration
// - no bit count; newest bits win
// - words are 16 or 25 bits
// - plain receive word: D15=0,D14=1,D8=0
// - host uses plain word below top rate
// - recovery word prefix 101000000, D15..14=0
// - host uses recovery word at top rate
// - data valid at recovered clock fall
// - D7 selects 10.368 or 13.824 MHz reference
// - D6..D5 give main divisor 86..89
// - D4..D0 give swallow divisor 0..31
// - frequency code 32*main+swallow, rx minus one
// - D11..D9 trim 60 to 130 percent
// - trim applies only to transmit words
// - regulator line powers regulators
// - transceiver line powers shared blocks
// - receive line enables receive chain
// - transmit line enables amp and ramp
// - open loop disable holds loop closed
// - host leaves 250 ns between transfers
// - host waits settling before using frequency; this host only flags it in status bit 1 and takes the next word at once
// - transmit word: D14=1, D8=1
module cfg_port_host
    import cfg_port_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    cfg_link_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cfg_port_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [4:0] ctrl_q;
    logic [24:0] word_q;
    logic long_q, go_q, busy_q;
    logic aw_got_q, w_got_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;

    wire logic aw_take = s_axi_awvalid && !aw_got_q;
    wire logic w_take = s_axi_wvalid && !w_got_q;
    wire logic [3:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
    wire logic [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
    wire logic wr_fire = (aw_got_q || aw_take) && (w_got_q || w_take)
        && !s_axi_bvalid;
    wire logic wr_word = wr_fire && wa == REG_WORD && !busy_q;
    wire logic wr_ctrl = wr_fire && wa == REG_CTRL;
    wire logic wr_bad = wr_fire && !(wr_ctrl || wa == REG_WORD);
    // status bit 1 stays up while the synthesizer settles after a latch
    logic [15:0] settle_q;
    wire logic settling = settle_q != 16'h0000;
    wire logic [31:0] rd_mux = s_axi_araddr == REG_CTRL ? {27'h0, ctrl_q}
        : s_axi_araddr == REG_WORD ? {6'h00, long_q, word_q}
        : {30'h0, settling, busy_q};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl_q <= 5'h00;
            word_q <= 25'h000_0000;
            long_q <= 1'b0;
            go_q <= 1'b0;
        end
        else
        begin
            go_q <= wr_word;
            if (aw_take)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_fire)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_bad || (wa == REG_WORD && busy_q))
                    ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= wd[4:0];
            // bit 25 asks for the long, clock-recovery word
            if (wr_word)
            begin
                word_q <= wd[24:0];
                long_q <= wd[25];
            end
        end
    end

    assign s_axi_awready = !aw_got_q;
    assign s_axi_wready = !w_got_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (s_axi_araddr == REG_CTRL
                || s_axi_araddr == REG_WORD || s_axi_araddr == REG_STAT)
                ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    typedef enum {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_GAP} eng_state_t;
    eng_state_t st_q;
    logic [7:0] tmr_q;
    logic [CNT_W-1:0] bit_q;
    logic sclk_q, sdata_q, en_n_q;
    wire logic tmr_done = tmr_q == 8'h00;
    wire logic [CNT_W-1:0] first_bit =
        long_q ? CNT_W'(WORD_BITS - 1) : CNT_W'(SHORT_BITS - 1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ST_IDLE;
            tmr_q <= 8'h00;
            bit_q <= '0;
            sclk_q <= 1'b0;
            sdata_q <= 1'b0;
            en_n_q <= 1'b1;
            busy_q <= 1'b0;
            settle_q <= 16'h0000;
        end
        else
        begin
            if (!tmr_done)
                tmr_q <= tmr_q - 8'h01;
            if (settling)
                settle_q <= settle_q - 16'h0001;
            case (st_q)
                ST_IDLE:
                    if (go_q)
                    begin
                        busy_q <= 1'b1;
                        en_n_q <= 1'b0;
                        bit_q <= first_bit;
                        sdata_q <= word_q[first_bit];
                        tmr_q <= 8'(LEAD_CYCLES);
                        st_q <= ST_LEAD;
                    end
                ST_LEAD, ST_LOW:
                    if (tmr_done)
                    begin
                        sclk_q <= 1'b1;
                        tmr_q <= 8'(HALF_CYCLES);
                        st_q <= ST_HIGH;
                    end
                ST_HIGH:
                    if (tmr_done)
                    begin
                        sclk_q <= 1'b0;
                        tmr_q <= 8'(HALF_CYCLES);
                        if (bit_q == '0)
                        begin
                            en_n_q <= 1'b1;
                            tmr_q <= 8'(GAP_CYCLES);
                            settle_q <= 16'(SETTLE_CYCLES);
                            st_q <= ST_GAP;
                        end
                        else
                        begin
                            bit_q <= bit_q - CNT_W'(1);
                            sdata_q <= word_q[bit_q - CNT_W'(1)];
                            st_q <= ST_LOW;
                        end
                    end
                ST_GAP:
                    if (tmr_done)
                    begin
                        busy_q <= 1'b0;
                        st_q <= ST_IDLE;
                    end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // link pins
    // ----------------------------------------
    assign link.serial_clock = sclk_q;
    assign link.serial_data = sdata_q;
    assign link.enable_n = en_n_q;
    assign link.regulator_power_up = ctrl_q[0];
    assign link.transceiver_power_up = ctrl_q[1];
    assign link.rx_on = ctrl_q[2];
    assign link.tx_on = ctrl_q[3];
    assign link.open_loop_disable = ctrl_q[4];
endmodule

/* rtl/cfg_port_pkg.sv */
package cfg_port_pkg;
    localparam int WORD_BITS = 25;
    localparam int SHORT_BITS = 16;
    localparam int CNT_W = 5;
    // 3-wire timing, ns, and derived cycle counts at 4 ns per cycle
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLOCK_PERIOD_MIN_NS = 100;
    localparam int GAP_MIN_NS = 250;
    localparam int SETUP_ENABLE_NS = 100;
    localparam int HALF_CYCLES =
        (CLOCK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYCLES =
        (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEAD_CYCLES =
        (SETUP_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // synthesizer settling after a latch
    localparam int SETTLE_NS = 200000;
    localparam int SETTLE_CYCLES = SETTLE_NS / CLK_PERIOD_NS;
    // field positions
    localparam int SWALLOW_LSB = 0;
    localparam int MAIN_LSB = 5;
    localparam int REF_SEL_BIT = 7;
    localparam int RX_TX_BIT = 8;
    localparam int TRIM_LSB = 9;
    localparam int MODE_BIT = 14;
    localparam int TOP_BIT = 15;
    localparam int PREFIX_LSB = 16;
    localparam logic [8:0] RECOVERY_PREFIX = 9'h140;
    localparam logic [6:0] MAIN_BASE = 7'h56;
    localparam logic [3:0] TRIM_BASE_PCT = 4'h6;
    // AXI4-Lite register offsets of the host controller
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WORD = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {WORD_RX_PLAIN, WORD_RX_RECOVERY, WORD_TX}
        word_kind_t;
endpackage

/* sim/cfg_port_checker.sv */
`timescale 1ns/10ps
module cfg_port_checker
    import cfg_port_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic enable_n
);
    // ----------------------------------------
    // run lengths, saturating so idle never wraps
    // ----------------------------------------
    logic [22:0] st_q;
    logic [22:0] st_d;
    logic sck_last_q, en_last_q;
    logic [7:0] run_q, en_run_q;
    logic [4:0] bits_q;
    assign {sck_last_q, en_last_q, run_q, en_run_q, bits_q} = st_q;
    assign st_d[22:21] = {serial_clock, enable_n};
    assign st_d[20:13] = (serial_clock == sck_last_q)
        ? run_q + {7'h00, ~&run_q} : 8'h01;
    assign st_d[12:5] = (enable_n == en_last_q)
        ? en_run_q + {7'h00, ~&en_run_q} : 8'h01;
    // rising clocks inside a frame only
    assign st_d[4:0] = enable_n ? 5'h00
        : bits_q + {4'h0, serial_clock & ~sck_last_q};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_q <= {1'h0, 1'h1, 8'hFF, 8'hFF, 5'h00};
        else
            st_q <= st_d;
    end
    // ----------------------------------------
    // programming bus wire protocol
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence frame_open;
        $fell(enable_n);
    endsequence
    sequence frame_close;
        ##[1:1000] $rose(enable_n);
    endsequence
    clock_idle_a: assert property (enable_n |-> !serial_clock)
        else $error("serial clock moved outside a frame");
    data_hold_a: assert property (serial_clock |-> $stable(serial_data))
        else $error("data changed while clock high");
    data_setup_a: assert property ($rose(serial_clock) |-> serial_data == $past(serial_data, 5))
        else $error("data not set up before clock rise");
    half_period_a: assert property ($changed(serial_clock) |-> run_q >= HALF_CYCLES)
        else $error("serial clock phase too short");
    enable_lead_a: assert property ($rose(serial_clock) |-> !enable_n && en_run_q >= LEAD_CYCLES)
        else $error("clock rose too soon after enable fell");
    word_length_a: assert property ($rose(enable_n) |-> bits_q == 5'h10 || bits_q == 5'h19)
        else $error("frame length not 16 or 25 bits");
    transfer_gap_a: assert property (frame_open |-> en_run_q >= GAP_CYCLES)
        else $error("gap between frames too short");
    frame_close_a: assert property (frame_open |-> frame_close)
        else $error("frame never closed");
endmodule

/* sim/transceiver_config_serial_port_tb.sv */
`timescale 1ns/10ps
module transceiver_config_serial_port_tb;
    import cfg_port_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ref_select_q;
    logic clock_recovery_q, tx_word_q, word_valid_q, regulators_on_q;
    logic shared_blocks_on_q, rx_chain_on_q, tx_chain_on_q;
    logic open_loop_allowed_q, config_strobe_q;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] main_divisor_q, m;
    logic [4:0] swallow_divisor_q, sc, lines_now;
    logic [11:0] freq_code_q;
    logic [7:0] deviation_pct_q;
    logic [35:0] cfg_now, e;
    int err_count, checks_done, strobes, sends;
    assign cfg_now = {main_divisor_q, swallow_divisor_q, freq_code_q,
        deviation_pct_q, clock_recovery_q, tx_word_q, word_valid_q,
        ref_select_q};
    assign lines_now = {open_loop_allowed_q, tx_chain_on_q, rx_chain_on_q,
        shared_blocks_on_q, regulators_on_q};
    // ----------------------------------------
    // both ends joined by the link
    // ----------------------------------------
    cfg_link_if u_cfg_link_if ();
    cfg_port_host u_cfg_port_host (
        .aclk, .aresetn, .link(u_cfg_link_if.host), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    cfg_port_device u_cfg_port_device (
        .aclk, .aresetn, .link(u_cfg_link_if.device), .ref_select_q,
        .main_divisor_q, .swallow_divisor_q, .freq_code_q,
        .deviation_pct_q, .clock_recovery_q, .tx_word_q, .word_valid_q,
        .regulators_on_q, .shared_blocks_on_q, .rx_chain_on_q,
        .tx_chain_on_q, .open_loop_allowed_q, .config_strobe_q
    );
    cfg_port_checker u_cfg_port_checker (
        .aclk, .aresetn, .serial_clock(u_cfg_link_if.serial_clock),
        .serial_data(u_cfg_link_if.serial_data),
        .enable_n(u_cfg_link_if.enable_n)
    );
    initial
    begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    // a frame takes well under 1000 cycles
    initial
    begin
        repeat (60000) @(posedge aclk);
        err_count++;
        end_sim();
    end
    always @(posedge aclk)
        if (config_strobe_q === 1'h1)
            strobes++;
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task chk(input string n, input logic [63:0] x, input logic [63:0] g);
        checks_done++;
        if (g !== x)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1)
                s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk("bresp", r, s_axi_bresp);
    endtask
    task rd(input logic [3:0] a, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1)
                s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        rv = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk("rresp", r, s_axi_rresp);
    endtask
    // md[1] long word, md[0] try a second word while busy
    task send(input logic [24:0] w, input logic [1:0] md);
        wr(REG_WORD, {6'h00, md[1], w}, RESP_OKAY);
        if (md[0])
            wr(REG_WORD, 32'h0, RESP_SLVERR);
        rv = 32'h1;
        while (rv[0] !== 1'h0)
            rd(REG_STAT, RESP_OKAY);
        chk("settling", 1'h1, rv[1]);
        sends++;
    endtask
    task end_sim();
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        e = {7'h56, 5'h00, 12'h000, 8'h64, 4'h0};
        chk("reset", e, cfg_now);
        for (int i = 0; i < 5; i++)
        begin
            wr(REG_CTRL, 32'h1 << i, RESP_OKAY);
            rd(REG_CTRL, RESP_OKAY);
            repeat (4) @(posedge aclk);
            chk("ctrl", 5'h1 << i, rv[4:0]);
            chk("lines", 5'h10 ^ (5'h1 << i), lines_now);
        end
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        wr(4'hC, 32'h1F, RESP_SLVERR);
        rd(4'hC, RESP_SLVERR);
        // don't-care bits all ones, trim must not move
        for (int i = 0; i < 8; i++)
        begin
            m = 7'h56 + {5'h00, i[1:0]};
            sc = i[2] ? 5'h1F : 5'h00;
            send({9'h000, 7'h3F, 1'h0, i[2], i[1:0], sc}, 2'h0);
            e = {m, sc, {m, 5'h00} + {7'h00, sc} - 12'h001, 8'h64, 3'h1,
                i[2]};
            chk("rx", e, cfg_now);
        end
        for (int i = 0; i < 8; i++)
        begin
            send({9'h000, 4'h4, i[2:0], 4'hF, 5'h19}, 2'h0);
            e = {7'h59, 5'h19, 12'hB39, 8'h3C + 8'h0A * i[2:0], 4'h5};
            chk("tx", e, cfg_now);
        end
        send({9'h140, 7'h1F, 2'h0, 2'h2, 5'h0A}, 2'h3);
        e = {7'h58, 5'h0A, 12'hB09, 8'h82, 4'hA};
        chk("recovery", e, cfg_now);
        // leading bits that miss the prefix fall back to 16 bits
        send({9'h0AB, 7'h3F, 1'h0, 1'h1, 2'h1, 5'h03}, 2'h2);
        e = {7'h57, 5'h03, 12'hAE2, 8'h82, 4'h3};
        chk("leading", e, cfg_now);
        chk("strobes", sends, strobes);
        end_sim();
    end
endmodule
